// ### rtl/flash_seq_pkg.sv
// Shared constants and carrier types for the flash page write sequencer.
// Assumes a 10 MHz system clock and a simple address/strobe register port.
package flash_seq_pkg;

  // Geometry of the page and of the latch buffer
  localparam int DATA_W = 32;
  localparam int ADDR_W = 8;
  localparam int PAGE_WORDS = 16;
  localparam int WIDX_W = 4;
  localparam int QUADS = 4;
  localparam int QUAD_LSB = 2;
  localparam int PAGE_W = 8;
  localparam int REGIONS = 4;
  localparam int REGION_LSB = 6;
  localparam int EV_W = 4;

  // Register offsets (byte addresses)
  localparam logic [ADDR_W-1:0] OFF_MODE = 8'h00;
  localparam logic [ADDR_W-1:0] OFF_CMD = 8'h04;
  localparam logic [ADDR_W-1:0] OFF_STATUS = 8'h08;
  localparam logic [ADDR_W-1:0] OFF_LOCK = 8'h0c;
  localparam logic [ADDR_W-1:0] OFF_INT = 8'h10;
  // Latch buffer window: 16 words from 0x40
  localparam logic [1:0] LATCH_SEL = 2'h1;
  localparam int LATCH_SEL_LSB = 6;
  localparam int WIDX_LSB = 2;

  // Command word layout and codes; the keyword value is arbitrary
  localparam logic [7:0] CMD_KEY = 8'ha5;
  localparam logic [7:0] OP_WRITE_PAGE = 8'h01;
  localparam logic [7:0] OP_UNLOCK = 8'h02;
  localparam logic [7:0] OP_LOCK = 8'h03;

  // Status, event and mask bit positions (one layout for all three)
  localparam int ST_READY = 0;
  localparam int ST_CMD_ERR = 1;
  localparam int ST_LOCK_ERR = 2;
  localparam int ST_FLASH_ERR = 3;

  // Reset values
  localparam logic [EV_W-1:0] MODE_RESET = 4'h0;
  localparam logic [REGIONS-1:0] LOCK_RESET = 4'h0;
  // Status comes out of reset ready, with no error flagged
  localparam logic [EV_W-1:0] STATUS_RESET = 4'h1;
  localparam logic [DATA_W-1:0] ERASED_WORD = 32'hffffffff;

  // Programming pulse times and their cycle counts (least times, rounded up)
  localparam int CLK_FREQ_KHZ = 10000;
  localparam int PROG_FULL_NS = 2000;
  localparam int PROG_SHORT_NS = 500;
  localparam int TMR_W = 8;

  function automatic logic [TMR_W-1:0] ns_to_cycles(input int ns);
    int c;
    c = (ns * (CLK_FREQ_KHZ / 1000) + 999) / 1000;
    if (c < 1)
    begin
      c = 1;
    end
    return TMR_W'(c);
  endfunction : ns_to_cycles

  localparam logic [TMR_W-1:0] PROG_FULL_CYC = ns_to_cycles(PROG_FULL_NS);
  localparam logic [TMR_W-1:0] PROG_SHORT_CYC = ns_to_cycles(PROG_SHORT_NS);

  // Carrier types
  typedef struct packed {
    logic [PAGE_W-1:0] page;
    logic [WIDX_W-1:0] word;
  } flash_addr_t;

  typedef struct packed {
    flash_addr_t addr;
    logic [DATA_W-1:0] wdata;
    logic prog;
    logic rd;
  } flash_req_t;

  typedef struct packed {
    logic [7:0] key;
    logic [7:0] spare;
    logic [PAGE_W-1:0] page;
    logic [7:0] op;
  } cmd_word_t;

endpackage : flash_seq_pkg

// ### rtl/prog_timer.sv
// Down counter that times one programming pulse.
// Assumes load is a single-cycle pulse; reload while counting restarts it.
`timescale 1ns/1ps
module prog_timer
  import flash_seq_pkg::*;
(
  // Clock and reset
  input wire logic clock,
  input wire logic rst,
  // Control
  input wire logic load,
  input wire logic [flash_seq_pkg::TMR_W-1:0] length,
  // Status
  output logic done
);

  logic [TMR_W-1:0] count;
  logic [TMR_W-1:0] next_count;

  // Load, then count down to zero
  always_comb
  begin
    next_count = count;
    if (load)
    begin
      next_count = length;
    end
    else if (count != '0)
    begin
      next_count = count - TMR_W'(1);
    end
  end

  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      count <= '0;
    end
    else
    begin
      count <= next_count;
    end
  end

  // Pulse in the last counted cycle, so the pulse lasts exactly length cycles
  assign done = (count == TMR_W'(1)) && !load;

endmodule : prog_timer

// ### rtl/latch_buffer.sv
// Page latch buffer in flip-flops with a written flag per 128-bit word.
// Assumes writes arrive only while the sequencer is idle.
`timescale 1ns/1ps
module latch_buffer
  import flash_seq_pkg::*;
(
  // Clock and reset
  input wire logic clock,
  input wire logic rst,
  // Write side
  input wire logic wr,
  input wire logic [flash_seq_pkg::WIDX_W-1:0] widx,
  input wire logic [flash_seq_pkg::DATA_W-1:0] wdata,
  input wire logic clear,
  // Read side
  input wire logic [flash_seq_pkg::WIDX_W-1:0] ridx,
  output logic [flash_seq_pkg::DATA_W-1:0] rdata,
  output logic [flash_seq_pkg::QUADS-1:0] dirty
);

  logic [DATA_W-1:0] mem [PAGE_WORDS];
  logic [DATA_W-1:0] next_mem [PAGE_WORDS];
  logic [QUADS-1:0] next_dirty;

  // Unwritten words stay erased so they never clear a flash bit
  always_comb
  begin
    next_mem = mem;
    next_dirty = dirty;
    if (clear)
    begin
      for (int i = 0; i < PAGE_WORDS; i++)
      begin
        next_mem[i] = ERASED_WORD;
      end
      next_dirty = '0;
    end
    else if (wr)
    begin
      next_mem[widx] = wdata;
      next_dirty[widx[WIDX_W-1:QUAD_LSB]] = 1'b1;
    end
  end

  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      for (int i = 0; i < PAGE_WORDS; i++)
      begin
        mem[i] <= ERASED_WORD;
      end
      dirty <= '0;
    end
    else
    begin
      mem <= next_mem;
      dirty <= next_dirty;
    end
  end

  assign rdata = mem[ridx];

endmodule : latch_buffer

// ### rtl/flash_page_write_sequencer.sv
// Sequencer that programs one flash page from the latch buffer.
// Assumes a 10 MHz clock, a one-cycle read-latency flash port and a simple register port.
// Function
// - Set the ready flag when page programming finishes.
// - Raise interrupt on ready rise when its enable bit is set.
// - Flag command error on a bad keyword in the command register.
// - Flag lock error when the target page sits in a locked region.
// - Verify the array after programming and flag flash error on mismatch.
// - Program one page per operation, fully or partially.
// - Write page clears every array bit held at zero in the latch.
// - Adapt write operations to the number of bits to program.
// - Count pending 128-bit words; one word uses a shortened sequence.
// - Several pending words use the normal page sequence.
//
// Decided for this implementation: strobed register access and the register offsets.
`timescale 1ns/1ps
module flash_page_write_sequencer
  import flash_seq_pkg::*;
(
  // Clock and reset
  input wire logic clock,
  input wire logic rst,
  // Register port
  input wire logic [flash_seq_pkg::ADDR_W-1:0] reg_addr,
  input wire logic [flash_seq_pkg::DATA_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [flash_seq_pkg::DATA_W-1:0] reg_rdata,
  // Flash array port
  output flash_seq_pkg::flash_req_t flash_req,
  input wire logic [flash_seq_pkg::DATA_W-1:0] flash_rdata,
  // Interrupt
  output logic irq
);

  typedef enum logic [2:0] {S_IDLE, S_SCAN, S_PROG, S_VERIFY, S_CHECK, S_DONE} state_t;

  // Number of written 128-bit words in the latch
  function automatic int unsigned quad_count(input logic [QUADS-1:0] d);
    int unsigned n;
    n = 0;
    for (int i = 0; i < QUADS; i++)
    begin
      n += int'(d[i]);
    end
    return n;
  endfunction : quad_count

  // Register state
  logic [EV_W-1:0] flash_mode_reg;
  logic [EV_W-1:0] flash_status_reg;
  logic [EV_W-1:0] int_status;
  logic [REGIONS-1:0] lock_bits;
  logic [DATA_W-1:0] next_rdata;
  logic [EV_W-1:0] next_mode;
  logic [EV_W-1:0] next_int;

  // Sequencer state
  state_t state;
  state_t next_state;
  logic [EV_W-1:0] next_status;
  logic [REGIONS-1:0] next_lock;
  logic [PAGE_W-1:0] page;
  logic [PAGE_W-1:0] next_page;
  logic [WIDX_W-1:0] widx;
  logic [WIDX_W-1:0] next_widx;
  logic short_seq;
  logic next_short_seq;
  logic [QUADS-1:0] quad_sel;
  logic [QUADS-1:0] next_quad_sel;
  flash_req_t next_req;

  // Helpers
  cmd_word_t cmd;
  logic cmd_wr;
  logic latch_wr;
  logic latch_clear;
  logic tmr_load;
  logic tmr_done;
  logic [DATA_W-1:0] latch_word;
  logic [QUADS-1:0] dirty;
  logic [EV_W-1:0] events;
  logic ready_prev;

  assign cmd = cmd_word_t'(reg_wdata);
  assign cmd_wr = reg_wr && (reg_addr == OFF_CMD);
  // Latch writes are dropped while busy so a running page stays intact
  assign latch_wr = reg_wr && flash_status_reg[ST_READY]
    && (reg_addr[ADDR_W-1:LATCH_SEL_LSB] == LATCH_SEL);

  latch_buffer u_latch (
    .clock(clock),
    .rst(rst),
    .wr(latch_wr),
    .widx(reg_addr[LATCH_SEL_LSB-1:WIDX_LSB]),
    .wdata(reg_wdata),
    .clear(latch_clear),
    .ridx(widx),
    .rdata(latch_word),
    .dirty(dirty)
  );

  prog_timer u_timer (
    .clock(clock),
    .rst(rst),
    .load(tmr_load),
    .length(short_seq ? PROG_SHORT_CYC : PROG_FULL_CYC),
    .done(tmr_done)
  );

  // Command handling and programming sequence
  always_comb
  begin
    next_state = state;
    next_status = flash_status_reg;
    next_lock = lock_bits;
    next_page = page;
    next_widx = widx;
    next_short_seq = short_seq;
    next_quad_sel = quad_sel;
    next_req = flash_req;
    next_req.prog = 1'b0;
    next_req.rd = 1'b0;
    tmr_load = 1'b0;
    latch_clear = 1'b0;
    case (state)
      S_IDLE:
      begin
        if (cmd_wr)
        begin
          next_status = '0;
          next_status[ST_READY] = 1'b1;
          if (cmd.key != CMD_KEY)
          begin
            next_status[ST_CMD_ERR] = 1'b1;
          end
          else if (cmd.op == OP_UNLOCK)
          begin
            next_lock[cmd.page[PAGE_W-1:REGION_LSB]] = 1'b0;
          end
          else if (cmd.op == OP_LOCK)
          begin
            next_lock[cmd.page[PAGE_W-1:REGION_LSB]] = 1'b1;
          end
          else if (cmd.op != OP_WRITE_PAGE)
          begin
            // Unknown operation under a good keyword also counts as bad command
            next_status[ST_CMD_ERR] = 1'b1;
          end
          else if (lock_bits[cmd.page[PAGE_W-1:REGION_LSB]])
          begin
            next_status[ST_LOCK_ERR] = 1'b1;
          end
          else
          begin
            next_status[ST_READY] = 1'b0;
            next_page = cmd.page;
            next_widx = '0;
            // One pending word takes the short path
            next_short_seq = (quad_count(dirty) == 1);
            next_quad_sel = dirty;
            next_state = S_SCAN;
          end
        end
      end
      S_SCAN:
      begin
        // Normal sequence walks every word of the page
        if (!short_seq || quad_sel[widx[WIDX_W-1:QUAD_LSB]])
        begin
          // Zero bits in the latch clear array bits
          next_req.addr.page = page;
          next_req.addr.word = widx;
          next_req.wdata = latch_word;
          next_req.prog = 1'b1;
          tmr_load = 1'b1;
          next_state = S_PROG;
        end
        else if (widx == WIDX_W'(PAGE_WORDS - 1))
        begin
          next_state = S_DONE;
        end
        else
        begin
          next_widx = widx + WIDX_W'(1);
        end
      end
      S_PROG:
      begin
        // Pulse length follows the amount to program
        next_req.prog = !tmr_done;
        if (tmr_done)
        begin
          next_req.rd = 1'b1;
          next_state = S_VERIFY;
        end
      end
      S_VERIFY:
      begin
        // Read strobe is on the port this cycle; data arrives next cycle
        next_state = S_CHECK;
      end
      S_CHECK:
      begin
        // Every zero in the latch must read back as zero
        if ((flash_rdata & ~latch_word) != '0)
        begin
          next_status[ST_FLASH_ERR] = 1'b1;
        end
        if (widx == WIDX_W'(PAGE_WORDS - 1))
        begin
          next_state = S_DONE;
        end
        else
        begin
          next_widx = widx + WIDX_W'(1);
          next_state = S_SCAN;
        end
      end
      S_DONE:
      begin
        // Ready rises at the end of the page
        next_status[ST_READY] = 1'b1;
        latch_clear = 1'b1;
        next_state = S_IDLE;
      end
      default:
      begin
        next_state = S_IDLE;
      end
    endcase
  end

  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      state <= S_IDLE;
      flash_status_reg <= STATUS_RESET;
      lock_bits <= LOCK_RESET;
      page <= '0;
      widx <= '0;
      short_seq <= 1'b0;
      quad_sel <= '0;
      flash_req <= '0;
    end
    else
    begin
      state <= next_state;
      flash_status_reg <= next_status;
      lock_bits <= next_lock;
      page <= next_page;
      widx <= next_widx;
      short_seq <= next_short_seq;
      quad_sel <= next_quad_sel;
      flash_req <= next_req;
    end
  end

  // Events: ready rising edge, and each error as it is raised
  assign events[ST_READY] = flash_status_reg[ST_READY] && !ready_prev;
  assign events[ST_CMD_ERR] = next_status[ST_CMD_ERR] && !flash_status_reg[ST_CMD_ERR];
  assign events[ST_LOCK_ERR] = next_status[ST_LOCK_ERR] && !flash_status_reg[ST_LOCK_ERR];
  assign events[ST_FLASH_ERR] = next_status[ST_FLASH_ERR] && !flash_status_reg[ST_FLASH_ERR];

  // Register writes, sticky interrupt bits and read data
  always_comb
  begin
    next_mode = flash_mode_reg;
    next_int = int_status;
    next_rdata = '0;
    if (reg_wr && (reg_addr == OFF_MODE))
    begin
      next_mode = reg_wdata[EV_W-1:0];
    end
    // Write one to clear; a new event in the same cycle wins over the clear
    if (reg_wr && (reg_addr == OFF_INT))
    begin
      next_int = int_status & ~reg_wdata[EV_W-1:0];
    end
    next_int = next_int | events;
    if (reg_rd)
    begin
      case (reg_addr)
        OFF_MODE: next_rdata = DATA_W'(flash_mode_reg);
        OFF_STATUS: next_rdata = DATA_W'(flash_status_reg);
        OFF_LOCK: next_rdata = DATA_W'(lock_bits);
        OFF_INT: next_rdata = DATA_W'(int_status);
        default: next_rdata = '0;
      endcase
    end
  end

  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      flash_mode_reg <= MODE_RESET;
      int_status <= '0;
      reg_rdata <= '0;
      ready_prev <= 1'b1;
    end
    else
    begin
      flash_mode_reg <= next_mode;
      int_status <= next_int;
      reg_rdata <= next_rdata;
      ready_prev <= flash_status_reg[ST_READY];
    end
  end

  // Mode register bits enable the interrupt sources
  assign irq = |(int_status & flash_mode_reg);

endmodule : flash_page_write_sequencer

// ### verification/flash_seq_monitor.sv
// Port checker for the flash page write sequencer.
// Assumes it is bound to the top module and sees only its ports.
`timescale 1ns/1ps
module flash_seq_monitor
  import flash_seq_pkg::*;
(
  // Clock and reset
  input wire logic clock,
  input wire logic rst,
  // Register port
  input wire logic [flash_seq_pkg::ADDR_W-1:0] reg_addr,
  input wire logic [flash_seq_pkg::DATA_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [flash_seq_pkg::DATA_W-1:0] reg_rdata,
  // Flash port and interrupt
  input flash_seq_pkg::flash_req_t flash_req,
  input wire logic [flash_seq_pkg::DATA_W-1:0] flash_rdata,
  input wire logic irq
);
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (rst);

  logic [4:0] plen;
  logic [3:0] quiet;
  logic [3:0] mode_sh;

  // Shadows of pulse length, idle time and mode; the checker cannot see inside
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      plen <= 5'h00;
      quiet <= 4'h0;
      mode_sh <= MODE_RESET;
    end
    else
    begin
      plen <= flash_req.prog ? plen + 5'h01 : 5'h00;
      quiet <= (flash_req.prog || flash_req.rd) ? 4'h0 : quiet + {3'h0, quiet != 4'hf};
      if (reg_wr && reg_addr == OFF_MODE)
      begin
        mode_sh <= reg_wdata[3:0];
      end
    end
  end

  a_prog_len: assert property ($fell(flash_req.prog) |-> plen == 5'h05 || plen == 5'h14)
    else $error("programming pulse length wrong");
  a_rd_after: assert property ($fell(flash_req.prog) |-> flash_req.rd)
    else $error("no verify read after pulse");
  a_rd_pulse: assert property (flash_req.rd |=> !flash_req.rd && !flash_req.prog)
    else $error("verify read not a lone pulse");
  a_word_hold: assert property (flash_req.prog && $past(flash_req.prog) |->
    $stable(flash_req.addr) && $stable(flash_req.wdata))
    else $error("word moved during pulse");
  a_one_page: assert property (flash_req.rd |-> ##3
    (!flash_req.prog || flash_req.addr.page == $past(flash_req.addr.page, 3)))
    else $error("page changed within operation");
  a_irq_mask: assert property (irq |-> mode_sh != 4'h0)
    else $error("interrupt while all enables off");
  a_err_quiet: assert property (reg_wr && reg_addr == OFF_CMD && reg_wdata[31:24] != CMD_KEY
    && quiet >= 4'h4 |=> !flash_req.prog [*4])
    else $error("bad keyword started programming");
  a_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == '0)
    else $error("read data outside its cycle");

  c_short: cover property ($fell(flash_req.prog) && plen == 5'h05);
  c_full: cover property ($fell(flash_req.prog) && plen == 5'h14);
  c_irq: cover property ($rose(irq));
endmodule : flash_seq_monitor

bind flash_page_write_sequencer flash_seq_monitor u_flash_seq_monitor (.clock(clock),
  .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
  .reg_rdata(reg_rdata), .flash_req(flash_req), .flash_rdata(flash_rdata), .irq(irq));

// ### verification/flash_array_model.sv
// Behavioural flash array behind the sequencer's flash port.
// Assumes one-cycle read latency; contents survive reset like real flash.
`timescale 1ns/1ps
module flash_array_model
  import flash_seq_pkg::*;
(
  // Clock
  input wire logic clock,
  // Flash port
  input flash_seq_pkg::flash_req_t flash_req,
  output logic [flash_seq_pkg::DATA_W-1:0] flash_rdata,
  // Fault: bit 0 of every word stays erased
  input wire logic stuck
);
  logic [DATA_W-1:0] mem [0:4095];
  wire [11:0] idx = flash_req.addr;

  // Array starts erased
  initial
  begin
    flash_rdata = '0;
    for (int i = 0; i < 4096; i++)
    begin
      mem[i] = ERASED_WORD;
    end
  end

  // programming only clears bits, apart from bit 0 that stuck forces to one
  // Read data is valid one cycle only, then keeps changing so stale use shows up
  always @(posedge clock)
  begin
    if (flash_req.prog)
    begin
      mem[idx] <= (mem[idx] & flash_req.wdata) | {31'h0, stuck};
    end
    flash_rdata <= flash_req.rd ? mem[idx] : ~flash_rdata;
  end
endmodule : flash_array_model

// ### verification/flash_page_write_sequencer_tb_top.sv
// Self-checking bench for the flash page write sequencer.
// Assumes the array model and the bound port checker.
`timescale 1ns/1ps
module flash_page_write_sequencer_tb_top;
  import flash_seq_pkg::*;
  logic clock, rst, reg_wr, reg_rd, irq, stuck;
  logic [ADDR_W-1:0] reg_addr;
  logic [DATA_W-1:0] reg_wdata, reg_rdata, flash_rdata, v;
  flash_req_t flash_req;
  int fails = 0, checked = 0, cyc = 0, pc = 0, p0;

  // 10 MHz clock
  initial
  begin
    clock = 1'b0;
    forever #50 clock = ~clock;
  end

  // Pulse cycle count and hang guard
  always @(posedge clock)
  begin
    cyc <= cyc + 1;
    pc <= pc + int'(flash_req.prog);
    if (cyc == 5000)
    begin
      fails++;
      give_verdict();
    end
  end

  flash_page_write_sequencer u_flash_page_write_sequencer (.clock(clock), .rst(rst),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .flash_req(flash_req), .flash_rdata(flash_rdata), .irq(irq));
  flash_array_model u_flash_array_model (.clock(clock), .flash_req(flash_req),
    .flash_rdata(flash_rdata), .stuck(stuck));

  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp)
    begin
      fails++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask : cmp

  // One-cycle strobes; a spare cycle keeps each strobe to one assignment per step
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clock);
    reg_wr <= 1'b0;
    @(posedge clock);
  endtask : wr

  task automatic rd(input logic [7:0] a);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clock);
    reg_rd <= 1'b0;
    @(negedge clock);
    v = reg_rdata;
    @(posedge clock);
  endtask : rd

  task automatic chk(input logic [7:0] a, input logic [31:0] exp);
    rd(a);
    cmp(v, exp);
  endtask : chk

  task automatic cmd(input logic [7:0] pg, input logic [7:0] op);
    wr(OFF_CMD, {CMD_KEY, 8'h00, pg, op});
  endtask : cmd

  // only status is polled while busy; latch filled ascending in whole quads
  task automatic page(input logic [7:0] pg, input int q, input int n, input logic [31:0] b);
    int k;
    for (int i = 4 * q; i < 4 * (q + n); i++)
    begin
      wr(8'h40 + 8'(4 * i), b + i);
    end
    p0 = pc;
    cmd(pg, OP_WRITE_PAGE);
    k = 0;
    rd(OFF_STATUS);
    while (v[ST_READY] !== 1'b1 && k < 400)
    begin
      rd(OFF_STATUS);
      k++;
    end
    cmp(32'(v[ST_READY]), 32'h1);
  endtask : page

  task automatic note(input string s);
    $display("test %s done", s);
  endtask : note

  task automatic give_verdict;
    $display("checked %0d fails %0d", checked, fails);
    if (fails == 0 && checked > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : give_verdict

  initial
  begin
    rst = 1'b1;
    reg_addr = '0;
    reg_wdata = '0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    stuck = 1'b0;
    repeat (5) @(posedge clock);
    rst <= 1'b0;
    @(posedge clock);
    chk(OFF_STATUS, 32'h1);
    chk(OFF_MODE, 32'h0);
    chk(OFF_LOCK, 32'h0);
    chk(8'h20, 32'h0);
    chk(8'h40, 32'h0);
    note("reset");
    // Bad keyword, then good keyword with an unknown operation
    wr(OFF_CMD, 32'h5a000301);
    chk(OFF_STATUS, 32'h3);
    cmd(8'h03, 8'h07);
    chk(OFF_STATUS, 32'h3);
    note("command error");
    // Locked region refuses the page and leaves the array alone
    cmd(8'h40, OP_LOCK);
    chk(OFF_STATUS, 32'h1);
    chk(OFF_LOCK, 32'h2);
    p0 = pc;
    cmd(8'h45, OP_WRITE_PAGE);
    chk(OFF_STATUS, 32'h5);
    cmp(32'(pc - p0), 32'h0);
    cmd(8'h45, OP_UNLOCK);
    chk(OFF_LOCK, 32'h0);
    note("lock");
    // One 128-bit word, ready interrupt enabled
    wr(OFF_INT, 32'hf);
    wr(OFF_MODE, 32'h1);
    page(8'h03, 1, 1, 32'h12340000);
    cmp(32'(pc - p0), 32'h14);
    for (int i = 4; i < 8; i++) cmp(u_flash_array_model.mem[48 + i], 32'h12340000 + i);
    cmp(u_flash_array_model.mem[48], ERASED_WORD);
    chk(OFF_STATUS, 32'h1);
    cmp(32'(irq), 32'h1);
    chk(OFF_INT, 32'h1);
    wr(OFF_INT, 32'h1);
    cmp(32'(irq), 32'h0);
    note("short word");
    // full page over an erased page, interrupt masked
    wr(OFF_MODE, 32'h0);
    page(8'h05, 0, 4, 32'h5a5a0000);
    cmp(32'(pc - p0), 32'h140);
    for (int i = 0; i < 16; i++) cmp(u_flash_array_model.mem[80 + i], 32'h5a5a0000 + i);
    cmp(32'(irq), 32'h0);
    chk(OFF_INT, 32'h1);
    wr(OFF_INT, 32'h1);
    note("full page");
    // Array bit that will not clear fails the verify; only the error interrupt enabled
    wr(OFF_MODE, 32'h8);
    stuck <= 1'b1;
    page(8'h07, 0, 1, 32'h0);
    chk(OFF_STATUS, 32'h9);
    chk(OFF_INT, 32'h9);
    cmp(32'(irq), 32'h1);
    stuck <= 1'b0;
    note("verify");
    give_verdict();
  end
endmodule : flash_page_write_sequencer_tb_top
